// ---- shared/pcs_pkg.sv ----
// constants for the port change-status, driver-disable and input block
// assumes a 32-bit AXI4-Lite register bus and one system clock

package pcs_pkg;

	localparam int PORT_COUNT = 3;
	localparam int PIN_COUNT = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] SUMMARY_OFF = 8'h00;
	localparam logic [7:0] DRV_BASE_OFF = 8'h04;
	localparam logic [7:0] IN_BASE_OFF = 8'h10;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h1C;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h20;
	localparam logic [7:0] REG_STRIDE = 8'h04;

	// summary field positions, one per port, then the lowest reserved bit
	localparam int SUM_BIT_A = 0;
	localparam int SUM_BIT_B = 1;
	localparam int SUM_BIT_C = 2;
	localparam int SUM_RESERVED_LO = 3;

	// values after reset
	localparam logic [15:0] DRV_DIS_RESET = 16'hFFFF;
	localparam logic [15:0] PIN_RESET = 16'h0000;
	localparam logic [2:0] FLAG_RESET = 3'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- src/pcs_port_status.sv ----
// port change-status summary, pin driver disable and pin input value
// assumes per-pin change flags and output latch values come from logic
// on the same clock; pin inputs are asynchronous and are synchronised here
`timescale 1ns/1ps

// How it works
// (RQ1) port C change sets summary bit 2
// (RQ2) port B change sets summary bit 1
// (RQ3) port A change sets summary bit 0
// (RQ4) summary zero when no flags remain set
// (RQ5) summary bits 15 to 3 read zero
// (RQ6) disable bit one stops latch driving pin
// (RQ7) input register reads current pin value
// (RQ8) any per-pin flag sets port summary
// (RQ9) summary clears once all port flags clear
// (RQ10) software writes never alter summary flags
module pcs_port_status #(
	parameter int PIN_COUNT = pcs_pkg::PIN_COUNT
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic clockEnable,
	input wire logic [pcs_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [pcs_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [2:0][PIN_COUNT-1:0] perPinChangeFlag,
	input wire logic [2:0][PIN_COUNT-1:0] outputLatchValue,
	input wire logic [2:0][PIN_COUNT-1:0] pinIn,
	output logic [2:0][PIN_COUNT-1:0] pinOut,
	output logic [2:0][PIN_COUNT-1:0] pinOe,
	output logic irq
);

	localparam int P = pcs_pkg::PORT_COUNT;
	localparam int N = PIN_COUNT;

	// byte lanes above bit 15 never exist in these registers
	if (PIN_COUNT < 1 || PIN_COUNT > 16) begin : gCheck
		$error("PIN_COUNT must be 1 to 16");
	end

	typedef struct packed {
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [1:0] rResp;
		logic [31:0] rData;
		logic [P-1:0][N-1:0] drvDis;
		logic [P-1:0][N-1:0] sync1;
		logic [P-1:0][N-1:0] sync2;
		logic [P-1:0][N-1:0] pinOut;
		logic [P-1:0][N-1:0] pinOe;
		logic [P-1:0] summary;
		logic [P-1:0] status;
		logic [P-1:0] mask;
		logic irq;
	} pcs_state_type;

	pcs_state_type state_reg;
	pcs_state_type state_next;

	logic [P-1:0] summaryNow;
	logic wrFire;
	logic rdFire;

	function automatic logic [7:0] regAddr(input logic [7:0] base, input int idx);
		return base + 8'(idx) * pcs_pkg::REG_STRIDE;
	endfunction

	// two byte-lane merge of a 16-bit word under byte strobes
	function automatic logic [N-1:0] laneMerge(input logic [N-1:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] merged;
		merged = 16'(old);
		if (strb[0]) begin
			merged[7:0] = data[7:0];
		end
		if (strb[1]) begin
			merged[15:8] = data[15:8];
		end
		return merged[N-1:0];
	endfunction

	// summary is a pure function of the per-pin flags, so it can never be
	// set or cleared by software; it follows them one clock later
	for (genvar p = 0; p < P; p++) begin : gSummary
		assign summaryNow[p] = |perPinChangeFlag[p]; // RQ8 RQ9
	end

	assign wrFire = state_reg.awReady && state_reg.wReady;
	assign rdFire = state_reg.arReady;

	always_comb begin
		logic [7:0] wAddr;
		logic [7:0] rAddr;
		logic [31:0] rWord;
		logic rHit;
		logic wHit;
		wAddr = {awaddr[7:2], 2'h0};
		rAddr = {araddr[7:2], 2'h0};
		rWord = 32'h0000_0000;
		rHit = 1'b0;
		wHit = 1'b0;
		state_next = state_reg;

		// write channel: wait for address and data together
		// a new write waits until its response is taken: one outstanding only
		state_next.awReady = 1'b0;
		state_next.wReady = 1'b0;
		if (awvalid && wvalid && !state_reg.awReady && !state_reg.bValid) begin
			state_next.awReady = 1'b1;
			state_next.wReady = 1'b1;
		end
		if (state_reg.bValid && bready) begin
			state_next.bValid = 1'b0;
		end

		if (wrFire) begin
			for (int p = 0; p < P; p++) begin
				if (wAddr == regAddr(pcs_pkg::DRV_BASE_OFF, p)) begin
					state_next.drvDis[p] = laneMerge(state_reg.drvDis[p], wdata, wstrb);
					wHit = 1'b1;
				end
				// input registers accept writes and drop them
				if (wAddr == regAddr(pcs_pkg::IN_BASE_OFF, p)) begin
					wHit = 1'b1;
				end
			end
			// summary is read-only: the write is answered, nothing changes
			if (wAddr == pcs_pkg::SUMMARY_OFF) begin
				wHit = 1'b1; // RQ10
			end
			if (wAddr == pcs_pkg::IRQ_MASK_OFF) begin
				wHit = 1'b1;
				if (wstrb[0]) begin
					state_next.mask = wdata[P-1:0];
				end
			end
			if (wAddr == pcs_pkg::IRQ_STAT_OFF) begin
				wHit = 1'b1;
			end
			state_next.bValid = 1'b1;
			state_next.bResp = wHit ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
		end

		// read channel
		state_next.arReady = 1'b0;
		if (arvalid && !state_reg.arReady && !state_reg.rValid) begin
			state_next.arReady = 1'b1;
		end
		if (state_reg.rValid && rready) begin
			state_next.rValid = 1'b0;
		end
		if (rdFire) begin
			if (rAddr == pcs_pkg::SUMMARY_OFF) begin
				rWord[P-1:0] = state_reg.summary; // RQ5
				rHit = 1'b1;
			end
			for (int p = 0; p < P; p++) begin
				if (rAddr == regAddr(pcs_pkg::DRV_BASE_OFF, p)) begin
					rWord[N-1:0] = state_reg.drvDis[p];
					rHit = 1'b1;
				end
				if (rAddr == regAddr(pcs_pkg::IN_BASE_OFF, p)) begin
					rWord[N-1:0] = state_reg.sync2[p]; // RQ7
					rHit = 1'b1;
				end
			end
			if (rAddr == pcs_pkg::IRQ_STAT_OFF) begin
				rWord[P-1:0] = state_reg.status;
				rHit = 1'b1;
			end
			if (rAddr == pcs_pkg::IRQ_MASK_OFF) begin
				rWord[P-1:0] = state_reg.mask;
				rHit = 1'b1;
			end
			state_next.rValid = 1'b1;
			state_next.rData = rWord;
			state_next.rResp = rHit ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
		end

		// two-stage pin synchroniser
		// the first stage may be metastable, so only the second is read
		state_next.sync1 = pinIn;
		state_next.sync2 = state_reg.sync1; // RQ7

		state_next.summary = summaryNow; // RQ1 RQ2 RQ3 RQ4

		// rising summary raises sticky status; set beats a same-cycle clear
		if (wrFire && wAddr == pcs_pkg::IRQ_STAT_OFF && wstrb[0]) begin
			state_next.status = state_reg.status & ~wdata[P-1:0];
		end
		state_next.status = state_next.status | (summaryNow & ~state_reg.summary);
		state_next.irq = |(state_next.status & state_next.mask);

		// drive follows the new disable value on the same edge
		state_next.pinOut = outputLatchValue;
		state_next.pinOe = ~state_next.drvDis; // RQ6
	end

	// clock enable low holds every flop, bus outputs included
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
			state_reg.drvDis <= {P{pcs_pkg::DRV_DIS_RESET[N-1:0]}};
			state_reg.sync1 <= {P{pcs_pkg::PIN_RESET[N-1:0]}};
			state_reg.sync2 <= {P{pcs_pkg::PIN_RESET[N-1:0]}};
			state_reg.summary <= pcs_pkg::FLAG_RESET[P-1:0];
			state_reg.status <= pcs_pkg::FLAG_RESET[P-1:0];
			state_reg.mask <= pcs_pkg::FLAG_RESET[P-1:0];
		end else if (clockEnable) begin
			state_reg <= state_next;
		end
	end

	// every output leaves a flop of the state record
	assign awready = state_reg.awReady;
	assign wready = state_reg.wReady;
	assign bvalid = state_reg.bValid;
	assign bresp = state_reg.bResp;
	assign arready = state_reg.arReady;
	assign rvalid = state_reg.rValid;
	assign rresp = state_reg.rResp;
	assign rdata = state_reg.rData;
	assign pinOut = state_reg.pinOut;
	assign pinOe = state_reg.pinOe;
	assign irq = state_reg.irq;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	a_summary_port_c: assert property ( // RQ1
		clockEnable && |perPinChangeFlag[2] |=> state_reg.summary[pcs_pkg::SUM_BIT_C])
		else $error("port C summary not set");

	a_summary_port_b: assert property ( // RQ2
		clockEnable && |perPinChangeFlag[1] |=> state_reg.summary[pcs_pkg::SUM_BIT_B])
		else $error("port B summary not set");

	a_summary_port_a: assert property ( // RQ3
		clockEnable && |perPinChangeFlag[0] |=> state_reg.summary[pcs_pkg::SUM_BIT_A])
		else $error("port A summary not set");

	a_summary_idle_zero: assert property ( // RQ4
		clockEnable && perPinChangeFlag == '0 |=> state_reg.summary == '0)
		else $error("summary set with no flags");

	a_summary_upper_zero: assert property ( // RQ5
		clockEnable && rdFire && araddr == pcs_pkg::SUMMARY_OFF
		|=> rvalid && rdata[31:pcs_pkg::SUM_RESERVED_LO] == '0)
		else $error("summary reserved bits nonzero");

	a_driver_disable: assert property ( // RQ6
		clockEnable && wrFire && awaddr == pcs_pkg::DRV_BASE_OFF && wstrb[1:0] == 2'h3
		|=> pinOe[0] == ~$past(wdata[N-1:0]) ##1 pinOe[0] == $past(~state_reg.drvDis[0]))
		else $error("pin enable does not follow disable");

	a_input_value: assert property ( // RQ7
		clockEnable && rdFire && araddr == pcs_pkg::IN_BASE_OFF
		|=> rdata[N-1:0] == $past(state_reg.sync2[0]) && rresp == pcs_pkg::RESP_OKAY)
		else $error("input read does not match pins");

	a_summary_cause: assert property ( // RQ8
		$rose(state_reg.summary[pcs_pkg::SUM_BIT_B]) |-> $past(|perPinChangeFlag[1]))
		else $error("summary rose without a flag");

	a_summary_clear: assert property ( // RQ9
		clockEnable && state_reg.summary[0] && perPinChangeFlag[0] == '0
		|=> !state_reg.summary[pcs_pkg::SUM_BIT_A])
		else $error("summary did not clear");

	a_summary_no_write: assert property ( // RQ10
		clockEnable && wrFire && awaddr == pcs_pkg::SUMMARY_OFF
		|=> state_reg.summary == $past(summaryNow) && bvalid)
		else $error("write altered summary");

	a_irq_level: assert property (
		clockEnable && |(state_next.status & state_next.mask) |=> irq)
		else $error("interrupt missing");

	a_cause_port_a: assert property ( // RQ8
		$rose(state_reg.summary[pcs_pkg::SUM_BIT_A]) |-> $past(|perPinChangeFlag[0]))
		else $error("port A summary rose without a flag");

	a_cause_port_c: assert property ( // RQ8
		$rose(state_reg.summary[pcs_pkg::SUM_BIT_C]) |-> $past(|perPinChangeFlag[2]))
		else $error("port C summary rose without a flag");

	// the pins are only trusted after both stages, never from the first
	a_input_sync: assert property ( // RQ7
		resetn && clockEnable ##1 clockEnable |=> state_reg.sync2 == $past(pinIn, 2))
		else $error("input stage lost a pin value");

	a_latch_follow: assert property ( // RQ6
		resetn && clockEnable |=> pinOut == $past(outputLatchValue))
		else $error("pin output does not follow latch");

	// a clear that meets a new change must not lose it
	a_status_set: assert property (
		clockEnable && summaryNow[pcs_pkg::SUM_BIT_C] && !state_reg.summary[pcs_pkg::SUM_BIT_C]
		|=> state_reg.status[pcs_pkg::SUM_BIT_C])
		else $error("status missed a summary rise");

	a_status_sticky: assert property (
		clockEnable && state_reg.status[pcs_pkg::SUM_BIT_A]
		&& !(wrFire && awaddr[7:2] == pcs_pkg::IRQ_STAT_OFF[7:2] && wstrb[0] && wdata[0])
		|=> state_reg.status[pcs_pkg::SUM_BIT_A])
		else $error("status bit dropped without a clear");

	a_bvalid_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response withdrawn early");

	a_rvalid_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data withdrawn early");

	a_awready_pulse: assert property (
		clockEnable && awready |=> !awready)
		else $error("write address ready held too long");

	a_arready_pulse: assert property (
		clockEnable && arready |=> !arready)
		else $error("read address ready held too long");

	c_write_drive: cover property (wrFire && awaddr == pcs_pkg::DRV_BASE_OFF ##1 bvalid);
	c_summary_rise: cover property ($rose(state_reg.summary[pcs_pkg::SUM_BIT_C]) ##[1:20] irq);
	c_status_clear: cover property (wrFire && awaddr == pcs_pkg::IRQ_STAT_OFF ##1 !irq);
	c_bad_address: cover property (rvalid && rresp == pcs_pkg::RESP_SLVERR);
	c_input_read: cover property (rdFire && araddr == pcs_pkg::IN_BASE_OFF ##1 rvalid);

endmodule

// ---- verif/pcs_pin_model.sv ----
// pin pad model: each pin follows the block when enabled, else the outside level
// assumes pinOe high means the block drives the pin
`timescale 1ns/1ps
module pcs_pin_model (
	input wire logic [2:0][15:0] pinOut,
	input wire logic [2:0][15:0] pinOe,
	input wire logic [2:0][15:0] extLevel,
	output logic [2:0][15:0] pinIn
);
	// outside drivers only win where the block lets go
	assign pinIn = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule

// ---- verif/tb_port_direction_input_change_status.sv ----
// self-checking bench for the port status, driver disable and input block
// assumes the pin model on the pad side and an AXI4-Lite master here
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errCount++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_port_direction_input_change_status;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic clockEnable = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, value;
	logic [2:0][15:0] flags = '0, latch = '0, ext = '0, pinIn, pinOut, pinOe;
	int errCount = 0, checked = 0, cycles = 0;
	pcs_port_status dut (.clock(clock), .resetn(resetn), .clockEnable(clockEnable),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .perPinChangeFlag(flags), .outputLatchValue(latch),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
	pcs_pin_model pads (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic stopTest();
		$display("comparisons %0d mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// the run is under two hundred cycles; this only catches a stuck handshake
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			errCount++;
			stopTest();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready === 1'b1) begin
				awvalid <= 1'b0;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		value = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic tReset();
		rd(pcs_pkg::SUMMARY_OFF);
		`CHK(value, 32'h0)
		rd(pcs_pkg::DRV_BASE_OFF);
		`CHK(value, 32'h0000FFFF)
		`CHK(pinOe, 48'h0)
	endtask
	task automatic tSummary();
		for (int p = 0; p < 3; p++) begin
			flags[p] <= 16'h8001;
			wt(3);
			rd(pcs_pkg::SUMMARY_OFF);
			`CHK(value, 32'h1 << p)
			flags[p] <= 16'h0001;
			wt(3);
			rd(pcs_pkg::SUMMARY_OFF);
			`CHK(value, 32'h1 << p)
			flags[p] <= 16'h0000;
			wt(3);
			rd(pcs_pkg::SUMMARY_OFF);
			`CHK(value, 32'h0)
		end
	endtask
	task automatic tSoftWrite();
		flags <= {16'h0400, 16'h0020, 16'h0001};
		wt(3);
		wr(pcs_pkg::SUMMARY_OFF, 32'h0);
		`CHK(resp, pcs_pkg::RESP_OKAY)
		rd(pcs_pkg::SUMMARY_OFF);
		`CHK(value, 32'h7)
		flags <= '0;
		wt(3);
		wr(pcs_pkg::SUMMARY_OFF, 32'hFFFFFFFF);
		rd(pcs_pkg::SUMMARY_OFF);
		`CHK(value, 32'h0)
	endtask
	task automatic tDriveInput();
		latch <= {16'h1234, 16'h5678, 16'h9ABC};
		ext <= {16'h00F0, 16'h0000, 16'hA5C3};
		wr(pcs_pkg::DRV_BASE_OFF + 8'h08, 32'h000000FF);
		`CHK(pinOe[2], 16'hFF00)
		`CHK(pinOut[2], 16'h1234)
		`CHK(pinOe[0], 16'h0000)
		wt(3);
		rd(pcs_pkg::IN_BASE_OFF);
		`CHK(value, 32'h0000A5C3)
		rd(pcs_pkg::IN_BASE_OFF + 8'h08);
		`CHK(value, 32'h000012F0)
		wr(pcs_pkg::DRV_BASE_OFF, 32'h0000F00F);
		`CHK(pinOe[0], 16'h0FF0)
		wr(pcs_pkg::DRV_BASE_OFF, 32'h0000AA55, 4'h2);
		rd(pcs_pkg::DRV_BASE_OFF);
		`CHK(value, 32'h0000AA0F)
		`CHK(pinOe[0], 16'h55F0)
		rd(pcs_pkg::IN_BASE_OFF);
		`CHK(value, 32'h0000B0B3)
	endtask
	task automatic tUnmapped();
		wr(8'h40, 32'h1);
		`CHK(resp, pcs_pkg::RESP_SLVERR)
		rd(8'h40);
		`CHK(resp, pcs_pkg::RESP_SLVERR)
		`CHK(value, 32'h0)
	endtask
	task automatic tIrq();
		wr(pcs_pkg::IRQ_STAT_OFF, 32'h7);
		wr(pcs_pkg::IRQ_MASK_OFF, 32'h1);
		flags[0] <= 16'h0010;
		wt(5);
		`CHK(irq, 1'b1)
		flags[0] <= 16'h0000;
		wr(pcs_pkg::IRQ_STAT_OFF, 32'h1);
		wt(2);
		`CHK(irq, 1'b0)
		flags[1] <= 16'h0100;
		wt(5);
		`CHK(irq, 1'b0)
		rd(pcs_pkg::IRQ_STAT_OFF);
		`CHK(value, 32'h2)
		flags[1] <= 16'h0000;
	endtask
	// enable low must hold outputs and hide new changes until it returns
	task automatic tFreeze();
		wt(1);
		clockEnable <= 1'b0;
		latch[1] <= 16'hC3C3;
		flags[0] <= 16'h0004;
		wt(4);
		`CHK(pinOut[1], 16'h5678)
		`CHK(irq, 1'b0)
		clockEnable <= 1'b1;
		wt(2);
		`CHK(pinOut[1], 16'hC3C3)
		`CHK(irq, 1'b1)
		flags[0] <= 16'h0000;
	endtask
	initial begin
		wt(20);
		resetn <= 1'b1;
		@(posedge clock);
		tReset();
		tSummary();
		tSoftWrite();
		tDriveInput();
		tUnmapped();
		tIrq();
		tFreeze();
		stopTest();
	end
endmodule
